// ### rtl/pmx_port_mux.sv
// port mode and bus multiplexer: wishbone registers and pin function muxing
//
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ns
module pmx_port_mux
   import pmx_pkg::*;
(
   input  logic              clk,
   input  logic              rst_n,
   input  logic              wb_cyc_i,
   input  logic              wb_stb_i,
   input  logic              wb_we_i,
   input  logic [PMX_AW-1:0] wb_adr_i,
   input  logic [3:0]        wb_sel_i,
   input  logic [PMX_DW-1:0] wb_dat_i,
   output logic [PMX_DW-1:0] wb_dat_o,
   output logic              wb_ack_o,
   input  logic [7:0]        portaIn,
   output logic [7:0]        portaOut,
   output logic [7:0]        portaOe,
   input  logic [7:0]        portbIn,
   output logic [7:0]        portbOut,
   output logic [7:0]        portbOe,
   input  logic [7:0]        portcIn,
   output logic [7:0]        portcOut,
   output logic [7:0]        portcOe,
   input  logic [7:0]        portdIn,
   output logic [7:0]        portdOut,
   output logic [7:0]        portdOe,
   input  logic [1:0]        addrHigh,
   input  logic              counterBOutData,
   input  logic              txSerialData,
   output logic              counterBInput,
   output logic              rxSerialIn,
   output logic              rxShiftClk,
   output logic              rxShiftModeActive
);

   pmx_state_type st_ff;
   pmx_state_type nxt_st;
   logic [31:0]   pinSync;
   logic          req;
   logic          strobeRise;

   // true when the bus address hits the given register offset
   function automatic logic hitReg(input logic [PMX_AW-1:0] adr, input logic [7:0] off);
      hitReg = (adr == off);
   endfunction

   // every pin input crosses two flops before use
   pmx_sync #(
      .W(32)
   ) u_pin_sync (
      .clk  (clk),
      .rst_n(rst_n),
      .din  ({portdIn, portcIn, portbIn, portaIn}),
      .dout (pinSync)
   );

   // bus slave, latch capture and pin function selection
   always_comb begin
      nxt_st = st_ff;
      req = wb_cyc_i & wb_stb_i & ~st_ff.ack;
      strobeRise = pinSync[PMX_PA_STROBE] & ~st_ff.strobePrev;

      // classic wishbone: ack one cycle after request, drops the next
      nxt_st.ack = req;
      nxt_st.rdat = 8'h00;
      if (req && !wb_we_i) begin
         if (hitReg(wb_adr_i, PMX_OFF_MODE_CTL)) begin
            nxt_st.rdat = st_ff.modeCtl;
         end else if (hitReg(wb_adr_i, PMX_OFF_SER_CTL)) begin
            nxt_st.rdat = st_ff.serCtl;
         end else if (hitReg(wb_adr_i, PMX_OFF_PORT_A)) begin
            nxt_st.rdat = pinSync[7:0];
         end else if (hitReg(wb_adr_i, PMX_OFF_PORT_B)) begin
            // latched mode returns the stored value, not live pins
            nxt_st.rdat = st_ff.modeCtl[PMX_PB_LATCH_EN] ? st_ff.pbLatch : pinSync[15:8];
         end else if (hitReg(wb_adr_i, PMX_OFF_PORT_C)) begin
            nxt_st.rdat = pinSync[23:16];
         end else if (hitReg(wb_adr_i, PMX_OFF_PORT_D)) begin
            nxt_st.rdat = pinSync[31:24];
         end
      end

      // writes land on the edge that raises ack; unmapped writes are dropped
      if (req && wb_we_i && wb_sel_i[0]) begin
         if (hitReg(wb_adr_i, PMX_OFF_MODE_CTL)) begin
            nxt_st.modeCtl = wb_dat_i[7:0];
         end else if (hitReg(wb_adr_i, PMX_OFF_SER_CTL)) begin
            nxt_st.serCtl = wb_dat_i[7:0];
         end else if (hitReg(wb_adr_i, PMX_OFF_PORT_A)) begin
            nxt_st.paData = wb_dat_i[7:0];
         end else if (hitReg(wb_adr_i, PMX_OFF_PORT_B)) begin
            nxt_st.pbData = wb_dat_i[7:0];
         end else if (hitReg(wb_adr_i, PMX_OFF_PORT_C)) begin
            nxt_st.pcData = wb_dat_i[7:0];
         end else if (hitReg(wb_adr_i, PMX_OFF_PORT_D)) begin
            nxt_st.pdData = wb_dat_i[7:0];
         end
      end

      // rising edge on the strobe pin captures port B
      nxt_st.strobePrev = pinSync[PMX_PA_STROBE];
      if (st_ff.modeCtl[PMX_PB_LATCH_EN] && strobeRise) begin
         nxt_st.pbLatch = pinSync[15:8];
      end

      // a port bit at 1 releases the pin to its pull-up, 0 pulls it low
      nxt_st.paOut = st_ff.paData;
      nxt_st.paOe  = ~st_ff.paData;
      nxt_st.pbOut = st_ff.pbData;
      nxt_st.pbOe  = ~st_ff.pbData;
      nxt_st.pcOut = st_ff.pcData;
      nxt_st.pcOe  = ~st_ff.pcData;

      // shift mode only with receiver on and both selects set
      nxt_st.shiftMode = st_ff.serCtl[PMX_RX_ENABLE] & st_ff.serCtl[PMX_RX_SEL_HI]
                         & st_ff.serCtl[PMX_RX_SEL_LO];
      if (st_ff.shiftMode) begin
         nxt_st.paOe[PMX_PA_SHIFT_CLK] = 1'b0;
      end
      nxt_st.shiftClk = st_ff.shiftMode & pinSync[PMX_PA_SHIFT_CLK];

      // counter B pin: input wins over output when the high bit is set
      nxt_st.cntbIn = 1'b0;
      if (st_ff.modeCtl[PMX_COUNTER_B_PIN_MODE_HI]) begin
         nxt_st.paOe[PMX_PA_COUNTER_B_PIN] = 1'b0;
         nxt_st.cntbIn = pinSync[PMX_PA_COUNTER_B_PIN];
      end else if (st_ff.modeCtl[PMX_COUNTER_B_PIN_MODE_LO]) begin
         nxt_st.paOut[PMX_PA_COUNTER_B_PIN] = counterBOutData;
         nxt_st.paOe[PMX_PA_COUNTER_B_PIN]  = 1'b1;
      end

      // serial output driven hard, not through the pull-up
      if (st_ff.serCtl[PMX_TX_ENABLE]) begin
         nxt_st.paOut[PMX_PA_TX] = txSerialData;
         nxt_st.paOe[PMX_PA_TX]  = 1'b1;
      end

      // serial input idles high like a quiet line
      nxt_st.rxIn = 1'b1;
      if (st_ff.serCtl[PMX_RX_ENABLE]) begin
         nxt_st.paOe[PMX_PA_RX] = 1'b0;
         nxt_st.rxIn = pinSync[PMX_PA_RX];
      end

      // latched input mode floats all of port B
      if (st_ff.modeCtl[PMX_PB_LATCH_EN]) begin
         nxt_st.pbOe = 8'h00;
      end

      // full address mode hands the top two port C pins to the address bus
      if (st_ff.modeCtl[PMX_BUS_MODE_SEL]) begin
         nxt_st.pcOut[PMX_PC_ADDR_LO+1:PMX_PC_ADDR_LO] = addrHigh;
         nxt_st.pcOe[PMX_PC_ADDR_LO+1:PMX_PC_ADDR_LO]  = 2'h3;
      end

      // port D switches as a whole; no per-bit direction exists
      nxt_st.pdOut = st_ff.pdData;
      nxt_st.pdOe  = {8{st_ff.modeCtl[PMX_PD_DRIVE_SEL]}};
   end

   // single state register, synchronous reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= PMX_STATE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // all outputs come straight from the state register
   assign wb_ack_o          = st_ff.ack;
   assign wb_dat_o          = {24'h000000, st_ff.rdat};
   assign portaOut          = st_ff.paOut;
   assign portaOe           = st_ff.paOe;
   assign portbOut          = st_ff.pbOut;
   assign portbOe           = st_ff.pbOe;
   assign portcOut          = st_ff.pcOut;
   assign portcOe           = st_ff.pcOe;
   assign portdOut          = st_ff.pdOut;
   assign portdOe           = st_ff.pdOe;
   assign counterBInput     = st_ff.cntbIn;
   assign rxSerialIn        = st_ff.rxIn;
   assign rxShiftClk        = st_ff.shiftClk;
   assign rxShiftModeActive = st_ff.shiftMode;

   // checks on the pin muxing and the bus handshake
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence wbRequest;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence

   sequence ackPulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   sequence strobeEdge;
      st_ff.modeCtl[PMX_PB_LATCH_EN] && strobeRise;
   endsequence

   wb_ack_pulse_a: assert property (wbRequest |=> ackPulse)
      else $error("wishbone ack not a single pulse after request");

   pb_bitwise_a: assert property (!$past(st_ff.modeCtl[PMX_PB_LATCH_EN]) |->
      (portbOe == ~$past(st_ff.pbData)))
      else $error("port B direction does not follow its data bits");

   pb_latch_float_a: assert property ($past(st_ff.modeCtl[PMX_PB_LATCH_EN]) |-> portbOe == 8'h00)
      else $error("port B driven while latch mode is on");

   pb_latch_capture_a: assert property (strobeEdge |=> st_ff.pbLatch == $past(pinSync[15:8]))
      else $error("port B latch missed strobe data");

   pc_addr_drive_a: assert property ($past(st_ff.modeCtl[PMX_BUS_MODE_SEL]) |->
      (portcOe[7:6] == 2'h3) && (portcOut[7:6] == $past(addrHigh)) && (portcOe[5:0] == ~$past(st_ff.pcData[5:0])))
      else $error("full address mode not driving high address");

   pc_io_mode_a: assert property (!$past(st_ff.modeCtl[PMX_BUS_MODE_SEL]) |->
      portcOe == ~$past(st_ff.pcData))
      else $error("port C not plain I/O in I/O bus mode");

   pd_whole_port_a: assert property ((portdOe == 8'h00) || (portdOe == 8'hFF))
      else $error("port D direction split");

   pd_drive_sel_a: assert property ($rose(st_ff.modeCtl[PMX_PD_DRIVE_SEL]) |=> portdOe == 8'hFF)
      else $error("port D drivers not enabled by drive select");

   rx_shift_mode_a: assert property (rxShiftModeActive == $past(&st_ff.serCtl[PMX_RX_ENABLE:PMX_RX_SEL_LO]))
      else $error("shift mode flag wrong");

   counter_b_pin_pin_a: assert property ($past(st_ff.modeCtl[PMX_COUNTER_B_PIN_MODE_LO:PMX_COUNTER_B_PIN_MODE_HI-1]) == 1'b1 &&
      !$past(st_ff.modeCtl[PMX_COUNTER_B_PIN_MODE_HI]) |-> portaOe[PMX_PA_COUNTER_B_PIN] && portaOut[PMX_PA_COUNTER_B_PIN] == $past(counterBOutData))
      else $error("counter B output not on pin");

   tx_pin_a: assert property ($past(st_ff.serCtl[PMX_TX_ENABLE]) |->
      portaOe[PMX_PA_TX] && (portaOut[PMX_PA_TX] == $past(txSerialData)))
      else $error("serial output not on pin");

   rx_pin_a: assert property ($past(st_ff.serCtl[PMX_RX_ENABLE]) |->
      !portaOe[PMX_PA_RX] && (rxSerialIn == $past(pinSync[PMX_PA_RX])))
      else $error("serial input pin not released or not passed on");

endmodule

// ### rtl/pmx_pkg.sv
// constants, register map and state type for the port mode and bus multiplexer
package pmx_pkg;

   // wishbone geometry
   localparam int PMX_DW = 32;
   localparam int PMX_AW = 8;

   // register byte offsets
   localparam logic [7:0] PMX_OFF_MODE_CTL = 8'h00;
   localparam logic [7:0] PMX_OFF_SER_CTL  = 8'h04;
   localparam logic [7:0] PMX_OFF_PORT_A   = 8'h08;
   localparam logic [7:0] PMX_OFF_PORT_B   = 8'h0C;
   localparam logic [7:0] PMX_OFF_PORT_C   = 8'h10;
   localparam logic [7:0] PMX_OFF_PORT_D   = 8'h14;

   // mode control register fields
   localparam int PMX_COUNTER_B_PIN_MODE_LO = 2;
   localparam int PMX_COUNTER_B_PIN_MODE_HI = 3;
   localparam int PMX_PB_LATCH_EN  = 4;
   localparam int PMX_PD_DRIVE_SEL = 5;
   localparam int PMX_BUS_MODE_SEL = 7;

   // serial control register fields
   localparam int PMX_RX_SEL_LO = 4;
   localparam int PMX_RX_SEL_HI = 5;
   localparam int PMX_RX_ENABLE = 6;
   localparam int PMX_TX_ENABLE = 7;

   // special pin positions
   localparam int PMX_PA_STROBE    = 0;
   localparam int PMX_PA_SHIFT_CLK = 4;
   localparam int PMX_PA_COUNTER_B_PIN      = 5;
   localparam int PMX_PA_TX        = 6;
   localparam int PMX_PA_RX        = 7;
   localparam int PMX_PC_ADDR_LO   = 6;

   // reset values
   localparam logic [7:0] PMX_MODE_CTL_RST = 8'h00;
   localparam logic [7:0] PMX_SER_CTL_RST  = 8'h00;
   localparam logic [7:0] PMX_PORT_RST     = 8'hFF;
   localparam logic [7:0] PMX_LATCH_RST    = 8'h00;

   typedef struct packed {
      logic       ack;
      logic [7:0] rdat;
      logic [7:0] modeCtl;
      logic [7:0] serCtl;
      logic [7:0] paData;
      logic [7:0] pbData;
      logic [7:0] pcData;
      logic [7:0] pdData;
      logic [7:0] pbLatch;
      logic       strobePrev;
      logic [7:0] paOut;
      logic [7:0] paOe;
      logic [7:0] pbOut;
      logic [7:0] pbOe;
      logic [7:0] pcOut;
      logic [7:0] pcOe;
      logic [7:0] pdOut;
      logic [7:0] pdOe;
      logic       cntbIn;
      logic       rxIn;
      logic       shiftClk;
      logic       shiftMode;
   } pmx_state_type;

   // port registers at all ones release the port A to C pins, drive select at 0 releases port D; pins idle undriven
   localparam pmx_state_type PMX_STATE_RST = '{
      ack: 1'b0, rdat: 8'h00,
      modeCtl: PMX_MODE_CTL_RST, serCtl: PMX_SER_CTL_RST,
      paData: PMX_PORT_RST, pbData: PMX_PORT_RST,
      pcData: PMX_PORT_RST, pdData: PMX_PORT_RST,
      pbLatch: PMX_LATCH_RST, strobePrev: 1'b1,
      paOut: PMX_PORT_RST, paOe: 8'h00, pbOut: PMX_PORT_RST, pbOe: 8'h00,
      pcOut: PMX_PORT_RST, pcOe: 8'h00, pdOut: PMX_PORT_RST, pdOe: 8'h00,
      cntbIn: 1'b0, rxIn: 1'b1, shiftClk: 1'b0, shiftMode: 1'b0};

endpackage

// ### rtl/pmx_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module pmx_sync #(
   parameter int W = 8
) (
   input  logic         clk,
   input  logic         rst_n,
   input  logic [W-1:0] din,
   output logic [W-1:0] dout
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } pmx_sync_state_type;

   pmx_sync_state_type st_ff;
   pmx_sync_state_type nxt_st;

   // meta feeds only the second stage, never any logic
   always_comb begin
      nxt_st.meta   = din;
      nxt_st.stable = st_ff.meta;
   end

   // idle value ones matches pulled-up pins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= '{meta: '1, stable: '1};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign dout = st_ff.stable;

endmodule

// ### dv/pmx_ext_model.sv
// pin-level model of the memory and peripherals wired to the four ports
`timescale 1ns/1ns
module pmx_ext_model (
   input  wire logic        clk,
   input  wire logic [31:0] devOut,
   input  wire logic [31:0] devOe,
   input  wire logic [31:0] extEn,
   input  wire logic [31:0] extVal,
   output logic      [31:0] pinLvl
);
   logic [7:0] dLast_ff;
   // ports A to C: device drive wins, else outside drive, else pull-up
   assign pinLvl[23:0] = (devOe[23:0] & devOut[23:0]) | (~devOe[23:0] & extEn[23:0] & extVal[23:0])
                       | (~devOe[23:0] & ~extEn[23:0]);
   // port D has no pull-up: a floating line must not look like a held value
   assign pinLvl[31:24] = (devOe[31:24] & devOut[31:24]) | (~devOe[31:24] & extEn[31:24] & extVal[31:24])
                        | (~devOe[31:24] & ~extEn[31:24] & ~dLast_ff);
   // last port D level, for the floating case
   always_ff @(posedge clk) begin
      dLast_ff <= pinLvl[31:24];
   end
endmodule

// ### dv/port_mode_and_bus_mux_tb.sv
// self-checking bench for the port mode and bus multiplexer
`timescale 1ns/1ns
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin errors++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module port_mode_and_bus_mux_tb;
   import pmx_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, devOut, devOe, pinLvl, extEn = 32'h0, extVal = 32'h0;
   logic [1:0] addrHigh = 2'b00;
   logic cbOut = 1'b0, txBit = 1'b1, cbIn, rxIn, shClk, shAct, ack;
   logic [7:0] rd;
   // serial control patterns: only the first turns on shift mode
   logic [7:0] serPat [4] = '{8'h70, 8'h60, 8'h50, 8'h30};
   int errors = 0, samplesChecked = 0, cycles = 0;
   always #25 clk = ~clk;
   pmx_port_mux dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .portaIn(pinLvl[7:0]), .portaOut(devOut[7:0]), .portaOe(devOe[7:0]),
      .portbIn(pinLvl[15:8]), .portbOut(devOut[15:8]), .portbOe(devOe[15:8]),
      .portcIn(pinLvl[23:16]), .portcOut(devOut[23:16]), .portcOe(devOe[23:16]),
      .portdIn(pinLvl[31:24]), .portdOut(devOut[31:24]), .portdOe(devOe[31:24]),
      .addrHigh(addrHigh), .counterBOutData(cbOut), .txSerialData(txBit), .counterBInput(cbIn),
      .rxSerialIn(rxIn), .rxShiftClk(shClk), .rxShiftModeActive(shAct));
   pmx_ext_model ext_u (.clk(clk), .devOut(devOut), .devOe(devOe), .extEn(extEn), .extVal(extVal),
      .pinLvl(pinLvl));
   task automatic stop_test();
      $display("errors %0d samples_checked %0d", errors, samplesChecked);
      if (errors == 0 && samplesChecked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // one classic cycle; the request is held until ack is sampled high at a rising edge, then released
   task automatic wbAccess(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h000000, d};
      // ack and data are read before this edge's updates land; seeing ack ends the wait, and only the hang guard ends a wait that never sees it
      do @(posedge clk); while (ack !== 1'b1);
      rd = rdat[7:0];
      if (w == 1'b0) `CHK(rdat[31:8], 24'h000000)
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   // pin effects land one edge after the take, two for shift mode; pin inputs two edges after change
   task automatic settle();
      repeat (5) @(negedge clk);
   endtask
   // hang guard, well above the length of the sequence
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin errors++; stop_test(); end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      wbAccess(0, PMX_OFF_MODE_CTL, 8'h00); `CHK(rd, PMX_MODE_CTL_RST)
      wbAccess(0, PMX_OFF_SER_CTL, 8'h00); `CHK(rd, PMX_SER_CTL_RST)
      `CHK(devOe, 32'h00000000)
      wbAccess(0, 8'hFC, 8'h00); `CHK(rd, 8'h00)
      wbAccess(1, PMX_OFF_PORT_B, 8'h5A); settle(); `CHK(devOe[15:8], 8'hA5)
      wbAccess(0, PMX_OFF_PORT_B, 8'h00); `CHK(rd, 8'h5A)
      @(posedge clk) begin extEn[15:0] <= 16'hFF01; extVal[15:0] <= 16'h3C00; end
      wbAccess(1, PMX_OFF_MODE_CTL, 8'h10); settle(); `CHK(devOe[15:8], 8'h00)
      repeat (3) @(posedge clk);
      extVal[0] <= 1'b1;
      settle();
      @(posedge clk) extVal[15:8] <= 8'hC3;
      settle(); wbAccess(0, PMX_OFF_PORT_B, 8'h00); `CHK(rd, 8'h3C)
      wbAccess(1, PMX_OFF_MODE_CTL, 8'h00); settle(); `CHK(devOe[15:8], 8'hA5)
      @(posedge clk) begin addrHigh <= 2'b10; extEn <= 32'h0; end
      wbAccess(1, PMX_OFF_PORT_C, 8'hC0); wbAccess(1, PMX_OFF_MODE_CTL, 8'h80); settle();
      `CHK(devOe[23:16], 8'hFF)
      `CHK(devOut[23:16], 8'h80)
      wbAccess(1, PMX_OFF_MODE_CTL, 8'h00); settle(); `CHK(devOe[23:16], 8'h3F)
      `CHK(devOut[23:22], 2'b11)
      wbAccess(1, PMX_OFF_PORT_D, 8'h96); wbAccess(1, PMX_OFF_MODE_CTL, 8'h20); settle();
      `CHK(devOe[31:24], 8'hFF)
      `CHK(devOut[31:24], 8'h96)
      @(posedge clk) begin extEn[31:24] <= 8'hFF; extVal[31:24] <= 8'h69; end
      wbAccess(1, PMX_OFF_MODE_CTL, 8'h00); settle(); `CHK(devOe[31:24], 8'h00)
      wbAccess(0, PMX_OFF_PORT_D, 8'h00); `CHK(rd, 8'h69)
      for (int i = 0; i < 4; i++) begin
         wbAccess(1, PMX_OFF_SER_CTL, serPat[i]);
         settle(); `CHK(shAct, i == 0)
         `CHK(shClk, i == 0)
      end
      // counter B data low, so a pin left to its port bit would read high
      @(posedge clk) begin cbOut <= 1'b0; extEn[7:0] <= 8'hA0; extVal[7:0] <= 8'h20; txBit <= 1'b0; end
      wbAccess(1, PMX_OFF_MODE_CTL, 8'h04); settle(); `CHK(devOe[5], 1'b1)
      `CHK(devOut[5], 1'b0)
      wbAccess(1, PMX_OFF_MODE_CTL, 8'h08); settle(); `CHK(devOe[5], 1'b0)
      `CHK(cbIn, 1'b1)
      wbAccess(1, PMX_OFF_MODE_CTL, 8'h00); settle(); `CHK(cbIn, 1'b0)
      wbAccess(1, PMX_OFF_SER_CTL, 8'hC0); settle(); `CHK(devOe[7:6], 2'b01)
      `CHK(devOut[6], 1'b0)
      `CHK(rxIn, 1'b0)
      stop_test();
   end
endmodule
